// [design/wa_pkg.sv]
// Operation
// - Double-width manual: first pattern after reset locks regardless.
// - Double-width manual: later patterns never move boundary unrequested.
// - Double-width manual lock holds until reset or a new align request.
// - Pattern-detect is high, one cycle late, for every cycle a pattern is found anywhere.
// - Single-width manual: request with pattern found gives lock next cycle.
// - Bit-slip: each slip request rising edge moves boundary by one bit.
// - Bit-slip: data-width slips return the boundary to its start.
// - Each slipped bit drops the earliest received bit.
// - Software slip bit rising edge slips one bit like the slip pin, one cycle sooner.
// - Auto mode has programmable gain, lose and error-decrement counts.
// - Auto mode hunts pattern, or complement with coding on; locks after gain count groups.
// - Auto mode drops lock after lose count errors without decrement.
// - Auto mode regains lock after another gain count of valid groups.
// - Deterministic mode drives clock-slip, then locks once aligned.
// - Deterministic mode realigns only on software align-enable rising edge.
// - Deterministic lock holds until reset or align-enable written to one.
// - Invalid group while locked raises decode-error; only auto mode's lose count drops lock.
// - With coding enabled the pattern matches in both disparities.
// - Outside bit-slip, an aligned word with the pattern in its low bits raises pattern-detect.
package wa_pkg;

  localparam int unsigned DATA_W = 20;
  localparam int unsigned SYM_W  = 10;
  localparam int unsigned HIST_W = 40;
  localparam int unsigned OFF_W  = 5;

  localparam logic [SYM_W-1:0] ALIGN_PATTERN = 10'h0fa;
  localparam logic [OFF_W-1:0] RESET_OFFSET  = 5'h00;
  localparam logic [OFF_W-1:0] SINGLE_W      = 5'h0a;
  localparam logic [OFF_W-1:0] DOUBLE_W      = 5'h14;

  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SLIP_SETTLE_NS = 40;
  localparam int unsigned SLIP_SETTLE_CYC =
    (SLIP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W = 4;

  typedef enum logic [1:0] {
    MODE_MANUAL,
    MODE_BITSLIP,
    MODE_AUTO,
    MODE_DETLAT
  } wa_mode_t;

  typedef struct packed {
    wa_mode_t    mode;
    logic        double_width;
    logic        coding_en;
    logic [7:0]  gain_m1;
    logic [5:0]  lose_m1;
    logic [7:0]  good_m1;
  } wa_cfg_t;

  typedef struct packed {
    logic lock;
    logic pattern_detect;
    logic decode_error;
  } wa_status_t;

endpackage

// [design/wa_edge_detect.sv]
`timescale 1ns/1ps
module wa_edge_detect #(
  parameter bit SYNC = 1'b1
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Level in, level and rising edge out
  input  wire logic level_in,
  output logic      level_out,
  output logic      rise
);

  logic meta;
  logic stable;
  logic last;

  // Pins pass two flops; same-clock inputs skip the first stage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end else begin
      meta   <= level_in;
      stable <= SYNC ? meta : level_in;
      last   <= stable;
    end
  end

  assign level_out = stable;
  assign rise      = stable & ~last;

endmodule // wa_edge_detect

// [design/wa_sync_fsm.sv]
`timescale 1ns/1ps
module wa_sync_fsm (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // Events
  input  wire logic       enable,
  input  wire logic       restart,
  input  wire logic       group_valid,
  input  wire logic       code_err,
  // Programmed counts, each stored minus one
  input  wire logic [7:0] gain_m1,
  input  wire logic [5:0] lose_m1,
  input  wire logic [7:0] good_m1,
  // State
  output logic            locked
);

  logic [8:0] vcnt;
  logic [6:0] ecnt;
  logic [8:0] gcnt;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      locked <= 1'b0;
      vcnt   <= 9'h000;
      ecnt   <= 7'h00;
      gcnt   <= 9'h000;
    end else if (!enable) begin
      locked <= 1'b0;
      vcnt   <= 9'h000;
      ecnt   <= 7'h00;
      gcnt   <= 9'h000;
    end else if (!locked) begin
      if (restart || code_err) begin
        vcnt <= 9'h000;
      end else if (group_valid) begin
        if (vcnt == {1'b0, gain_m1}) begin
          locked <= 1'b1;
          vcnt   <= 9'h000;
          ecnt   <= 7'h00;
          gcnt   <= 9'h000;
        end else begin
          vcnt <= vcnt + 9'h001;
        end
      end
    end else if (code_err) begin
      gcnt <= 9'h000;
      if (ecnt == {1'b0, lose_m1}) begin
        locked <= 1'b0;
        ecnt   <= 7'h00;
      end else begin
        ecnt <= ecnt + 7'h01;
      end
    end else if (ecnt != 7'h00) begin
      // Good groups only count while some error is outstanding
      if (gcnt == {1'b0, good_m1}) begin
        ecnt <= ecnt - 7'h01;
        gcnt <= 9'h000;
      end else begin
        gcnt <= gcnt + 9'h001;
      end
    end
  end

endmodule // wa_sync_fsm

// [design/rx_word_boundary_aligner.sv]
`timescale 1ns/1ps
module rx_word_boundary_aligner (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  // Configuration
  input  wire wa_pkg::wa_cfg_t            cfg,
  // Deserialized words
  input  wire logic [wa_pkg::DATA_W-1:0]  data_in,
  input  wire logic                       code_error,
  // Controller pins
  input  wire logic                       align_request_input,
  input  wire logic                       slip_request,
  // Software control bits
  input  wire logic                       soft_align_enable,
  input  wire logic                       soft_slip,
  // Aligned output
  output logic [wa_pkg::DATA_W-1:0]       aligned_data,
  output wa_pkg::wa_status_t              status,
  // Deserializer clock-slip
  output logic                            clock_slip,
  output logic [wa_pkg::OFF_W-1:0]        slip_boundary
);

  typedef enum logic [1:0] {
    DL_SEARCH,
    DL_SLIP,
    DL_WAIT,
    DL_LOCKED
  } dl_state_t;

  // Pattern or, with coding on, its opposite disparity form
  function automatic logic pat_match(input logic [wa_pkg::SYM_W-1:0] sym,
                                     input logic coding);
    pat_match = (sym == wa_pkg::ALIGN_PATTERN) ||
                (coding && (sym == ~wa_pkg::ALIGN_PATTERN));
  endfunction

  function automatic logic [wa_pkg::OFF_W-1:0] wrap_inc(
    input logic [wa_pkg::OFF_W-1:0] off,
    input logic [wa_pkg::OFF_W-1:0] width);
    wrap_inc = (off == width - 5'h01) ? 5'h00 : off + 5'h01;
  endfunction

  logic [wa_pkg::DATA_W-1:0]  prev;
  logic [wa_pkg::OFF_W-1:0]   offset;
  logic [wa_pkg::OFF_W-1:0]   next_offset;
  logic                       first_pending;
  logic                       armed;
  logic                       manual_lock;
  logic                       next_manual_lock;
  logic                       detect;
  logic                       err_flag;
  dl_state_t                  dl_state;
  logic [wa_pkg::OFF_W-1:0]   remaining;
  logic [wa_pkg::SETTLE_W-1:0] settle;
  logic                       auto_locked;

  wire [wa_pkg::OFF_W-1:0]  width = cfg.double_width ? wa_pkg::DOUBLE_W
                                                    : wa_pkg::SINGLE_W;
  wire [wa_pkg::HIST_W-1:0] hist  = cfg.double_width ? {data_in, prev}
                                  : {20'h0_0000, data_in[9:0], prev[9:0]};
  wire [wa_pkg::HIST_W-1:0] shifted = hist >> offset;
  wire [wa_pkg::DATA_W-1:0] window_word = cfg.double_width
                                  ? shifted[wa_pkg::DATA_W-1:0]
                                  : {10'h000, shifted[9:0]};

  wire is_manual = cfg.mode == wa_pkg::MODE_MANUAL;
  wire is_slip   = cfg.mode == wa_pkg::MODE_BITSLIP;
  wire is_auto   = cfg.mode == wa_pkg::MODE_AUTO;
  wire is_detlat = cfg.mode == wa_pkg::MODE_DETLAT;

  // Edge sources: pins are synchronised, software bits are not
  logic align_level;
  logic align_rise;
  logic slip_pin_rise;
  logic soft_slip_rise;
  logic soft_align_rise;

  wa_edge_detect #(.SYNC(1'b1)) u_align_pin (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .level_in  (align_request_input),
    .level_out (align_level),
    .rise      (align_rise)
  );

  wa_edge_detect #(.SYNC(1'b1)) u_slip_pin (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .level_in  (slip_request),
    .level_out (),
    .rise      (slip_pin_rise)
  );

  wa_edge_detect #(.SYNC(1'b0)) u_soft_slip (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .level_in  (soft_slip),
    .level_out (),
    .rise      (soft_slip_rise)
  );

  wa_edge_detect #(.SYNC(1'b0)) u_soft_align (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .level_in  (soft_align_enable),
    .level_out (),
    .rise      (soft_align_rise)
  );

  // Lowest boundary at which the pattern starts in this window
  logic                     found_any;
  logic [wa_pkg::OFF_W-1:0] found_pos;

  always_comb begin
    found_any = 1'b0;
    found_pos = wa_pkg::RESET_OFFSET;
    for (int p = wa_pkg::DATA_W - 1; p >= 0; p--) begin
      if ((5'(p) < width) &&
          pat_match(hist[p +: wa_pkg::SYM_W], cfg.coding_en)) begin
        found_any = 1'b1;
        found_pos = 5'(p);
      end
    end
  end

  wire found_cur = pat_match(window_word[wa_pkg::SYM_W-1:0], cfg.coding_en);

  // Manual mode decisions
  wire man_double  = is_manual && cfg.double_width;
  wire man_single  = is_manual && !cfg.double_width;
  wire man_realign = man_double && (first_pending || armed) && found_any;
  wire man_s_align = man_single && align_level && found_any;

  // Bit-slip: pin or software rising edge
  wire slip_event = is_slip && (slip_pin_rise || soft_slip_rise);

  // Auto mode hunts while unlocked, so boundary may move then only
  wire auto_move = is_auto && !auto_locked && found_any &&
                   (found_pos != offset);

  always_comb begin
    next_offset = offset;
    if (man_realign || man_s_align) begin
      next_offset = found_pos;
    end else if (slip_event) begin
      next_offset = wrap_inc(offset, width);
    end else if (auto_move) begin
      next_offset = found_pos;
    end else if (is_detlat) begin
      // Alignment happens in the deserializer, not here
      next_offset = wa_pkg::RESET_OFFSET;
    end
  end

  always_comb begin
    next_manual_lock = manual_lock;
    if (man_single) begin
      next_manual_lock = man_s_align;
    end else if (man_double) begin
      if (align_rise) begin
        next_manual_lock = 1'b0;
      end else if (man_realign) begin
        next_manual_lock = 1'b1;
      end
    end else begin
      next_manual_lock = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev        <= 20'h0_0000;
      offset      <= wa_pkg::RESET_OFFSET;
      manual_lock <= 1'b0;
    end else begin
      prev        <= data_in;
      offset      <= next_offset;
      manual_lock <= next_manual_lock;
    end
  end

  // A request that lands with a realign stays armed: set beats clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_pending <= 1'b1;
      armed         <= 1'b0;
    end else begin
      if (man_realign) begin
        first_pending <= 1'b0;
      end
      if (align_rise) begin
        armed <= 1'b1;
      end else if (man_realign) begin
        armed <= 1'b0;
      end
    end
  end

  // Automatic synchronisation with hysteresis
  wa_sync_fsm u_sync (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .enable      (is_auto),
    .restart     (auto_move),
    .group_valid (found_cur && !auto_move),
    .code_err    (code_error),
    .gain_m1     (cfg.gain_m1),
    .lose_m1     (cfg.lose_m1),
    .good_m1     (cfg.good_m1),
    .locked      (auto_locked)
  );

  // Deterministic-latency clock-slip sequencer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dl_state   <= DL_SEARCH;
      remaining  <= 5'h00;
      settle     <= 4'h0;
      clock_slip <= 1'b0;
    end else if (!is_detlat) begin
      dl_state   <= DL_SEARCH;
      remaining  <= 5'h00;
      settle     <= 4'h0;
      clock_slip <= 1'b0;
    end else begin
      clock_slip <= 1'b0;
      case (dl_state)
        DL_SEARCH: begin
          if (found_any && found_pos == 5'h00) begin
            dl_state <= DL_LOCKED;
          end else if (found_any) begin
            remaining <= found_pos;
            dl_state  <= DL_SLIP;
          end
        end
        DL_SLIP: begin
          clock_slip <= 1'b1;
          remaining  <= remaining - 5'h01;
          settle     <= 4'(wa_pkg::SLIP_SETTLE_CYC);
          dl_state   <= DL_WAIT;
        end
        DL_WAIT: begin
          // Let the slipped words reach the input before acting again
          if (settle != 4'h0) begin
            settle <= settle - 4'h1;
          end else if (remaining != 5'h00) begin
            dl_state <= DL_SLIP;
          end else begin
            dl_state <= DL_SEARCH;
          end
        end
        DL_LOCKED: begin
          if (soft_align_rise) begin
            dl_state <= DL_SEARCH;
          end
        end
        default: begin
          dl_state <= DL_SEARCH;
        end
      endcase
    end
  end

  wire lock_now = (is_manual && manual_lock) ||
                  (is_auto && auto_locked) ||
                  (is_detlat && dl_state == DL_LOCKED);

  // Decode error is reported; only the auto-mode lose count makes it cost the lock
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      detect       <= 1'b0;
      err_flag     <= 1'b0;
      aligned_data <= 20'h0_0000;
    end else begin
      detect       <= found_any;
      err_flag     <= lock_now && code_error;
      aligned_data <= window_word;
    end
  end

  // One driver for the whole status word
  assign status        = '{lock:           lock_now,
                           pattern_detect: detect,
                           decode_error:   err_flag};
  assign slip_boundary         = remaining;

endmodule // rx_word_boundary_aligner

// [tb/wa_aligner_asserts.sv]
`timescale 1ns/1ps
module wa_aligner_asserts (
  // Clock and reset
  input wire logic                         ref_clk,
  input wire logic                         reset_n,
  // Inputs watched
  input wire wa_pkg::wa_cfg_t              cfg,
  input wire logic                         code_error,
  input wire logic                         align_request_input,
  input wire logic                         soft_align_enable,
  // Outputs watched
  input wire logic [wa_pkg::DATA_W-1:0]    aligned_data,
  input wire wa_pkg::wa_status_t           status,
  input wire logic                         clock_slip,
  input wire logic [wa_pkg::OFF_W-1:0]     slip_boundary
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [2:0] quiet;
  logic       man2;
  // Requests reach the state only after sync, so wait well past it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) quiet <= 3'h0;
    else if (align_request_input || soft_align_enable) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  assign man2 = cfg.mode == wa_pkg::MODE_MANUAL && cfg.double_width;
  a_reset_clears: assert property ($rose(reset_n) |-> status == '0
    && !clock_slip && slip_boundary == '0) else $error("reset values");
  a_manual_hold: assert property (man2 && status.lock && quiet == 3'h7
    |=> status.lock) else $error("manual lock lost");
  a_detlat_hold: assert property (cfg.mode == wa_pkg::MODE_DETLAT
    && status.lock && quiet == 3'h7 |=> status.lock) else $error("det lock");
  a_single_pulse: assert property (cfg.mode == wa_pkg::MODE_MANUAL
    && !cfg.double_width && status.lock |=> !status.lock)
    else $error("single lock not a pulse");
  a_detect_bound: assert property (cfg.mode != wa_pkg::MODE_BITSLIP
    && aligned_data[9:0] == wa_pkg::ALIGN_PATTERN |-> status.pattern_detect)
    else $error("pattern at boundary not flagged");
  a_slip_spacing: assert property (clock_slip |=> !clock_slip [*5])
    else $error("clock slip too close");
  a_slip_detlat: assert property (cfg.mode != wa_pkg::MODE_DETLAT
    |-> !clock_slip) else $error("clock slip outside det mode");
  a_err_flag: assert property (status.decode_error |-> $past(code_error)
    && $past(status.lock)) else $error("decode error without cause");
  a_auto_loss: assert property ((cfg.mode == wa_pkg::MODE_AUTO
    && cfg.lose_m1 == 6'h01 && status.lock && code_error) ##1 code_error
    |-> ##[1:3] !status.lock) else $error("auto lock not lost");
  c_auto_lock: cover property (cfg.mode == wa_pkg::MODE_AUTO && status.lock);
  c_clock_slip: cover property (clock_slip);
  c_decode_err: cover property (status.decode_error);
endmodule // wa_aligner_asserts

bind rx_word_boundary_aligner wa_aligner_asserts u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .cfg(cfg), .code_error(code_error),
  .align_request_input(align_request_input),
  .soft_align_enable(soft_align_enable), .aligned_data(aligned_data),
  .status(status), .clock_slip(clock_slip), .slip_boundary(slip_boundary));

// [tb/wa_serdes_model.sv]
`timescale 1ns/1ps
module wa_serdes_model (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset_n,
  // Stream shape
  input  wire logic                    single,
  input  wire logic                    invert,
  input  wire logic                    load,
  input  wire logic [4:0]              phase_set,
  // From the aligner
  input  wire logic                    clock_slip,
  // Deserialized words
  output logic [wa_pkg::DATA_W-1:0]    data_in
);
  localparam logic [9:0] P = wa_pkg::ALIGN_PATTERN;
  logic [4:0]  phase;
  logic [39:0] twice;
  logic [19:0] pair;
  assign twice = {10'h000, P, 10'h000, P} >> phase;
  assign pair = {P, P} >> (phase % 5'h0a);
  assign data_in = single ? {10'h000, pair[9:0] ^ {10{invert}}} : twice[19:0];
  // A clock slip loses the earliest serial bit: phase steps by one
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) phase <= phase_set;
    else if (load) phase <= phase_set;
    else if (clock_slip) phase <= (phase == 5'h13) ? 5'h00 : phase + 5'h01;
  end
endmodule // wa_serdes_model

// [tb/rx_word_boundary_aligner_tb_top.sv]
`timescale 1ns/1ps
module rx_word_boundary_aligner_tb_top;
  localparam logic [19:0] S = 20'h0_00fa;
  localparam logic [9:0]  P = wa_pkg::ALIGN_PATTERN;
  logic               ref_clk = 1'b0;
  logic               reset_n = 1'b0;
  wa_pkg::wa_cfg_t    cfg = '0;
  logic [19:0]        data_in;
  logic               code_error = 1'b0;
  logic               align_request_input = 1'b0;
  logic               slip_request = 1'b0;
  logic               soft_align_enable = 1'b0;
  logic               soft_slip = 1'b0;
  logic [19:0]        aligned_data;
  wa_pkg::wa_status_t status;
  logic               clock_slip;
  logic [4:0]         slip_boundary;
  logic               single = 1'b0;
  logic               invert = 1'b0;
  logic               load = 1'b0;
  logic [4:0]         phase_set = 5'h00;
  int                 errors = 0;
  int                 n_compared = 0;
  int                 slips = 0;
  int                 c;
  initial forever #5 ref_clk = ~ref_clk;
  rx_word_boundary_aligner uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .cfg(cfg), .data_in(data_in), .code_error(code_error),
    .align_request_input(align_request_input), .slip_request(slip_request),
    .soft_align_enable(soft_align_enable), .soft_slip(soft_slip),
    .aligned_data(aligned_data), .status(status), .clock_slip(clock_slip),
    .slip_boundary(slip_boundary));
  wa_serdes_model partner (.ref_clk(ref_clk), .reset_n(reset_n),
    .single(single), .invert(invert), .load(load), .phase_set(phase_set),
    .clock_slip(clock_slip), .data_in(data_in));
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [19:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [19:0] rot(input int k);
    logic [39:0] t;
    t = {S, S} >> (k % 20);
    return t[19:0];
  endfunction
  // Bounded wait; slips seen on the way are counted
  task automatic wait_lock(input logic want, input int bound, output int n);
    n = 0;
    while (status.lock !== want) begin
      if (clock_slip === 1'b1) slips++;
      tick(1);
      n++;
      if (n > bound) begin
        check("lock wait", 20'(status.lock), 20'(want));
        end_of_test();
      end
    end
  endtask
  task automatic do_reset(input wa_pkg::wa_mode_t m, input logic dw,
                          input logic [4:0] ph);
    reset_n = 1'b0;
    cfg.mode = m;
    cfg.double_width = dw;
    single = !dw;
    phase_set = ph;
    tick(16);
    check("reset status", 20'(status), 20'h0_0000);
    check("reset slip", 20'({clock_slip, slip_boundary}), 20'h0_0000);
    reset_n = 1'b1;
    slips = 0;
  endtask
  task automatic pulse_req;
    align_request_input = 1'b1;
    tick(1);
    align_request_input = 1'b0;
  endtask
  task automatic slip1;
    soft_slip = 1'b1;
    tick(1);
    soft_slip = 1'b0;
    tick(3);
  endtask
  task automatic t_manual_double;
    do_reset(wa_pkg::MODE_MANUAL, 1'b1, 5'h05);
    wait_lock(1'b1, 20, c);
    tick(2);
    check("first lock", aligned_data, S);
    phase_set = 5'h09;
    load = 1'b1;
    tick(1);
    load = 1'b0;
    tick(10);
    check("boundary kept", aligned_data, rot(4));
    check("lock kept", 20'(status.lock), 20'h0_0001);
    check("detect off bound", 20'(status.pattern_detect), 20'h0_0001);
    pulse_req();
    wait_lock(1'b0, 8, c);
    wait_lock(1'b1, 20, c);
    tick(2);
    check("realigned", aligned_data, S);
    $display("manual double done");
  endtask
  task automatic t_manual_single;
    do_reset(wa_pkg::MODE_MANUAL, 1'b0, 5'h03);
    tick(4);
    pulse_req();
    wait_lock(1'b1, 10, c);
    tick(2);
    check("single aligned", aligned_data, {10'h000, P});
    $display("manual single done");
  endtask
  task automatic t_bitslip;
    do_reset(wa_pkg::MODE_BITSLIP, 1'b1, 5'h07);
    tick(4);
    c = 0;
    while (aligned_data[9:0] !== P && c < 20) begin
      slip1();
      c++;
    end
    check("slips to pattern", 20'(c), 20'h0_000d);
    for (int k = 1; k <= 20; k++) begin
      slip1();
      check("slip round", aligned_data, rot(k));
    end
    slip_request = 1'b1;
    tick(2);
    slip_request = 1'b0;
    tick(6);
    check("pin slip", aligned_data, rot(1));
    $display("bit slip done");
  endtask
  task automatic t_auto;
    do_reset(wa_pkg::MODE_AUTO, 1'b0, 5'h06);
    wait_lock(1'b1, 40, c);
    check("gain count", 20'(c >= 4), 20'h0_0001);
    tick(2);
    check("auto aligned", aligned_data, {10'h000, P});
    code_error = 1'b1;
    tick(1);
    code_error = 1'b0;
    check("decode error", 20'(status.decode_error), 20'h0_0001);
    check("lock on error", 20'(status.lock), 20'h0_0001);
    tick(6);
    code_error = 1'b1;
    tick(1);
    check("lock after decrement", 20'(status.lock), 20'h0_0001);
    tick(1);
    code_error = 1'b0;
    wait_lock(1'b0, 4, c);
    wait_lock(1'b1, 40, c);
    check("regain count", 20'(c >= int'(cfg.gain_m1) + 1), 20'h0_0001);
    cfg.coding_en = 1'b1;
    invert = 1'b1;
    do_reset(wa_pkg::MODE_AUTO, 1'b0, 5'h06);
    wait_lock(1'b1, 40, c);
    tick(2);
    check("complement", aligned_data, {10'h000, ~P});
    invert = 1'b0;
    $display("auto done");
  endtask
  task automatic t_detlat;
    do_reset(wa_pkg::MODE_DETLAT, 1'b1, 5'h11);
    wait_lock(1'b1, 200, c);
    check("slip pulses", 20'(slips), 20'h0_0003);
    tick(2);
    check("det aligned", aligned_data, S);
    phase_set = 5'h12;
    load = 1'b1;
    tick(1);
    load = 1'b0;
    pulse_req();
    tick(20);
    check("det lock kept", 20'(status.lock), 20'h0_0001);
    soft_align_enable = 1'b1;
    tick(1);
    soft_align_enable = 1'b0;
    slips = 0;
    wait_lock(1'b0, 4, c);
    wait_lock(1'b1, 200, c);
    check("realign slips", 20'(slips), 20'h0_0002);
    tick(2);
    check("det realigned", aligned_data, S);
    $display("deterministic done");
  endtask
  initial begin
    cfg.gain_m1 = 8'h03;
    cfg.lose_m1 = 6'h01;
    cfg.good_m1 = 8'h02;
    t_manual_double();
    t_manual_single();
    t_bitslip();
    t_auto();
    t_detlat();
    end_of_test();
  end
endmodule // rx_word_boundary_aligner_tb_top
